// [rtl/timer_cc_consts.svh]
// Register indices, field positions, reset values and codes of the timer channel
`ifndef TIMER_CC_CONSTS_SVH
`define TIMER_CC_CONSTS_SVH

// Register indices: byte address is four times the index
`define IDX_COUNT_CTRL   18'h05440
`define IDX_COUNTER      18'h05442
`define IDX_CC_CTRL      18'h05444
`define IDX_REG_A        18'h05446
`define IDX_REG_B        18'h05448
`define IDX_IRQ_EN       18'h0544A
`define IDX_IRQ_FLAG     18'h0544C

// Count control fields
`define BIT_RUN          0
`define BIT_CNT_RESET    1
`define BIT_ONE_SHOT     2

// Capture/compare control fields
`define BIT_CAP_MODE     0
`define BIT_INVERT       1
`define WAVE_LSB         4
`define EDGE_LSB         6

// Interrupt enable and flag fields
`define BIT_MATCH_A      0
`define BIT_MATCH_B      1
`define BIT_CAPTURE      2
`define BIT_OVERWRITE    4
`define IRQ_BITS         5
`define IRQ_IMPL_MASK    5'h17

// Reset values
`define RST_WORD         16'h0000
`define RST_IRQ          5'h00
`define RST_CODE         2'h0

// Capture edge and output wave codes
`define EDGE_NONE        2'h0
`define EDGE_RISE        2'h1
`define EDGE_FALL        2'h2
`define EDGE_BOTH        2'h3
`define WAVE_OFF         2'h0
`define WAVE_SET_A_CLR_B 2'h1
`define WAVE_TOGGLE_A    2'h2
`define WAVE_TOGGLE_B    2'h3

`endif

// [rtl/timer_cc_pkg.sv]
// Types shared by the timer channel modules
package timer_cc_pkg;
`include "timer_cc_consts.svh"

	// Capture edge selection
	typedef enum logic [1:0] {
		EDGE_NONE_E = `EDGE_NONE,
		EDGE_RISE_E = `EDGE_RISE,
		EDGE_FALL_E = `EDGE_FALL,
		EDGE_BOTH_E = `EDGE_BOTH
	} capture_edge_type;

	// Output waveform modes
	typedef enum logic [1:0] {
		WAVE_OFF_E      = `WAVE_OFF,
		WAVE_SET_CLR_E  = `WAVE_SET_A_CLR_B,
		WAVE_TOGGLE_A_E = `WAVE_TOGGLE_A,
		WAVE_TOGGLE_B_E = `WAVE_TOGGLE_B
	} wave_mode_type;

endpackage : timer_cc_pkg

// [rtl/cc_edge_detect.sv]
// Capture input edge detector with selectable edges
`timescale 1ns/1ns
module cc_edge_detect
	import timer_cc_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Input and selection
	input  wire logic             sig,
	input  wire capture_edge_type edge_sel,
	// Event
	output logic                  fire
);
	logic prev_reg;
	wire  rise_seen = sig & ~prev_reg;
	wire  fall_seen = ~sig & prev_reg;

	// Previous input level
	always_ff @(posedge clk) begin
		if (rst) prev_reg <= 1'b0;
		else     prev_reg <= sig;
	end

	// Edge selection
	always_comb begin
		case (edge_sel)
			EDGE_RISE_E: fire = rise_seen;
			EDGE_FALL_E: fire = fall_seen;
			EDGE_BOTH_E: fire = rise_seen | fall_seen;
			default:     fire = 1'b0;
		endcase
	end
endmodule : cc_edge_detect

// [rtl/cc_output_wave.sv]
// Timer output waveform generator with polarity control
`timescale 1ns/1ns
module cc_output_wave
	import timer_cc_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Configuration
	input  wire wave_mode_type mode,
	input  wire logic          invert,
	// Events
	input  wire logic          match_a,
	input  wire logic          match_b,
	input  wire logic          clear,
	// Pin level
	output logic               pin_out
);
	logic wave_reg;
	logic wave_next;

	// Waveform state per mode
	always_comb begin
		wave_next = wave_reg;
		case (mode)
			WAVE_SET_CLR_E: begin
				if (match_a)      wave_next = 1'b1;
				else if (match_b) wave_next = 1'b0;
			end
			WAVE_TOGGLE_A_E: if (match_a) wave_next = ~wave_reg;
			WAVE_TOGGLE_B_E: if (match_b) wave_next = ~wave_reg;
			default: wave_next = 1'b0;
		endcase
		if (clear) wave_next = 1'b0;
	end

	// State and registered pin level
	always_ff @(posedge clk) begin
		if (rst) begin
			wave_reg <= 1'b0;
			pin_out  <= 1'b0;
		end else begin
			wave_reg <= wave_next;
			pin_out  <= wave_next ^ invert;
		end
	end
endmodule : cc_output_wave

// [rtl/timer_capture_compare_ch.sv]
// One 16-bit timer channel with compare/capture and an APB register slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`include "timer_cc_consts.svh"

//****************************************************************
// Timer channel top
//****************************************************************

module timer_capture_compare_ch
	import timer_cc_pkg::*;
(
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [19:0] PADDR,
	input  wire logic [31:0] PWDATA,
	input  wire logic [3:0]  PSTRB,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Capture input and timer output
	input  wire logic        CAPTURE_IN,
	output logic             TIMER_OUT,
	// Interrupt
	output logic             IRQ
);

	//****************************************************************
	// Storage
	//****************************************************************

	// Registers and their next values
	logic [15:0]           count_reg;
	logic [15:0]           count_next;
	logic                  run_reg;
	logic                  run_next;
	logic                  one_shot_reg;
	logic                  one_shot_next;
	logic                  cap_mode_reg;
	logic                  invert_reg;
	capture_edge_type      edge_reg;
	wave_mode_type         wave_reg;
	logic [15:0]           reg_a_reg;
	logic [15:0]           reg_a_next;
	logic [15:0]           reg_b_reg;
	logic [15:0]           reg_b_next;
	logic [`IRQ_BITS-1:0]  irq_en_reg;
	logic [`IRQ_BITS-1:0]  irq_en_next;
	logic [`IRQ_BITS-1:0]  irq_flag_reg;
	logic [`IRQ_BITS-1:0]  irq_flag_next;
	logic [31:0]           rdata_reg;
	logic [31:0]           rdata_next;
	logic                  slverr_reg;

	//****************************************************************
	// Address decode
	//****************************************************************

	// Word index and register hits; one register per 32-bit word, so the
	// low two address bits are ignored and a byte offset still hits
	wire [17:0] word_idx   = PADDR[19:2];
	wire        hit_ctrl   = (word_idx == `IDX_COUNT_CTRL);
	wire        hit_count  = (word_idx == `IDX_COUNTER);
	wire        hit_cc     = (word_idx == `IDX_CC_CTRL);
	wire        hit_a      = (word_idx == `IDX_REG_A);
	wire        hit_b      = (word_idx == `IDX_REG_B);
	wire        hit_en     = (word_idx == `IDX_IRQ_EN);
	wire        hit_flag   = (word_idx == `IDX_IRQ_FLAG);
	wire        hit_any    = hit_ctrl | hit_count | hit_cc | hit_a
	                       | hit_b | hit_en | hit_flag;

	// Bus phases: setup latches read data, access edge commits writes
	// Latching at setup keeps PRDATA still through the whole access phase,
	// so a counter read returns one coherent value even while counting
	wire        setup_ph   = PSEL & ~PENABLE;
	wire        write_ph   = PSEL & PENABLE & PWRITE;

	// Per-register write strobes
	// Writes act only at the access edge, never in setup
	wire        wr_ctrl    = write_ph & hit_ctrl;
	wire        wr_cc      = write_ph & hit_cc;
	wire        wr_a       = write_ph & hit_a;
	wire        wr_b       = write_ph & hit_b;
	wire        wr_en      = write_ph & hit_en;
	wire        wr_flag    = write_ph & hit_flag;

	// Byte lane mask over the 16 live bits
	// Lanes above 15:8 carry no live bits and are ignored
	wire [15:0] wmask      = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
	wire [15:0] wbits      = PWDATA[15:0] & wmask;
	wire        lane0      = PSTRB[0];

	//****************************************************************
	// Counter core
	//****************************************************************

	// Counting step, period end and compare matches
	// Matches only count while running, so a counter parked on a compare
	// value raises no fresh flag on every idle cycle
	wire        count_step = run_reg;
	wire        period_end = count_step & (count_reg == reg_b_reg);
	wire        match_b    = period_end;
	wire        match_a    = count_step & ~cap_mode_reg
	                       & (count_reg == reg_a_reg);
	wire        cnt_clear  = wr_ctrl & lane0
	                       & PWDATA[`BIT_CNT_RESET];

	// Counter next value; a reset write wins over counting
	// A clear and a period end both land on zero, so their order is moot
	always_comb begin
		if (cnt_clear)       count_next = `RST_WORD;
		else if (period_end) count_next = `RST_WORD;
		else if (count_step) count_next = count_reg + 16'h0001;
		else                 count_next = count_reg;
	end

	// Run bit: software write, or self stop at one-shot period end
	// A run write in the stop cycle wins, so a restart is never lost
	always_comb begin
		if (wr_ctrl & lane0)
			run_next = PWDATA[`BIT_RUN];
		else if (period_end & one_shot_reg)
			run_next = 1'b0;
		else
			run_next = run_reg;
	end

	// Count mode bit
	// Taken from any count control write with lane 0 enabled
	assign one_shot_next = (wr_ctrl & lane0) ? PWDATA[`BIT_ONE_SHOT]
	                                         : one_shot_reg;

	//****************************************************************
	// Capture path
	//****************************************************************

	wire        edge_fire;
	wire        cap_fire   = edge_fire & cap_mode_reg;

	// Edge detector on the capture input
	// Edge codes are decoded inside the detector
	cc_edge_detect u_edge (
		.clk      (MCLK),
		.rst      (RST),
		.sig      (CAPTURE_IN),
		.edge_sel (edge_reg),
		.fire     (edge_fire)
	);

	// Register A: a capture takes priority over a software write
	// The captured count is the newer fact, so software loses the race
	always_comb begin
		if (cap_fire)
			reg_a_next = count_reg;
		else if (wr_a)
			reg_a_next = (reg_a_reg & ~wmask) | wbits;
		else
			reg_a_next = reg_a_reg;
	end

	// Register B
	// Register B also sets the period length in both count modes
	assign reg_b_next = wr_b ? ((reg_b_reg & ~wmask) | wbits)
	                         : reg_b_reg;

	//****************************************************************
	// Output waveform
	//****************************************************************

	// Waveform generator drives the registered pin level
	// A counter reset write also returns the waveform to its idle level
	cc_output_wave u_wave (
		.clk     (MCLK),
		.rst     (RST),
		.mode    (wave_reg),
		.invert  (invert_reg),
		.match_a (match_a),
		.match_b (match_b),
		.clear   (cnt_clear),
		.pin_out (TIMER_OUT)
	);

	//****************************************************************
	// Interrupt causes, enables and flags
	//****************************************************************

	// Hardware set events per flag position
	wire [`IRQ_BITS-1:0] irq_set;
	assign irq_set[`BIT_MATCH_A]   = match_a;
	assign irq_set[`BIT_MATCH_B]   = match_b;
	assign irq_set[`BIT_CAPTURE]   = cap_fire;
	// Reserved position 3 has no cause
	assign irq_set[3]              = 1'b0;
	// Overwrite only while the earlier capture flag is still pending
	assign irq_set[`BIT_OVERWRITE] = cap_fire
	                               & irq_flag_reg[`BIT_CAPTURE];

	// Write-one-to-clear pattern
	// Only strobed lanes can clear, and every flag lives in lane 0
	wire [`IRQ_BITS-1:0] irq_clr = wr_flag ? wbits[`IRQ_BITS-1:0]
	                                       : `RST_IRQ;
	wire [`IRQ_BITS-1:0] impl    = `IRQ_IMPL_MASK;

	// Flags and enables per bit; reserved positions stay zero
	genvar gi;
	generate
		for (gi = 0; gi < `IRQ_BITS; gi = gi + 1) begin : g_irq
			// Set wins over a clear in the same cycle
			assign irq_flag_next[gi] = impl[gi] &
				(irq_set[gi] | (irq_flag_reg[gi] & ~irq_clr[gi]));
			assign irq_en_next[gi] = impl[gi] &
				(wr_en ? wbits[gi] : irq_en_reg[gi]);
		end
	endgenerate

	// Level request from enabled flags
	// Combinational, so a clear drops the request in the same cycle
	assign IRQ = |(irq_flag_reg & irq_en_reg);

	//****************************************************************
	// Read mux
	//****************************************************************

	// Read words; reserved bits read zero
	// The write-only counter reset bit always reads back zero
	wire [15:0] rd_ctrl  = {13'h0000, one_shot_reg, 1'b0, run_reg};
	wire [15:0] rd_cc    = {8'h00, edge_reg, wave_reg, 2'h0,
	                        invert_reg, cap_mode_reg};
	wire [15:0] rd_en    = {11'h000, irq_en_reg};
	wire [15:0] rd_flag  = {11'h000, irq_flag_reg};

	// Word selection for the access phase
	// Unmapped words read zero and raise the slave error instead
	always_comb begin
		if (hit_ctrl)       rdata_next = {16'h0000, rd_ctrl};
		else if (hit_count) rdata_next = {16'h0000, count_reg};
		else if (hit_cc)    rdata_next = {16'h0000, rd_cc};
		else if (hit_a)     rdata_next = {16'h0000, reg_a_reg};
		else if (hit_b)     rdata_next = {16'h0000, reg_b_reg};
		else if (hit_en)    rdata_next = {16'h0000, rd_en};
		else if (hit_flag)  rdata_next = {16'h0000, rd_flag};
		else                rdata_next = 32'h00000000;
	end

	// Zero wait state slave
	// PSLVERR is gated with the access phase so it never shows in setup
	assign PREADY  = 1'b1;
	assign PRDATA  = rdata_reg;
	assign PSLVERR = slverr_reg & PSEL & PENABLE;

	//****************************************************************
	// Registers
	//****************************************************************

	// Counter and run control
	// Synchronous reset puts every register at its reset value
	always_ff @(posedge MCLK) begin
		if (RST) begin
			count_reg    <= `RST_WORD;
			run_reg      <= 1'b0;
			one_shot_reg <= 1'b0;
		end else begin
			count_reg    <= count_next;
			run_reg      <= run_next;
			one_shot_reg <= one_shot_next;
		end
	end

	// Capture/compare control; lane 0 holds every live field
	// Reserved bits are not stored, so they read back zero
	always_ff @(posedge MCLK) begin
		if (RST) begin
			cap_mode_reg <= 1'b0;
			invert_reg   <= 1'b0;
			edge_reg     <= EDGE_NONE_E;
			wave_reg     <= WAVE_OFF_E;
		end else if (wr_cc & lane0) begin
			cap_mode_reg <= PWDATA[`BIT_CAP_MODE];
			invert_reg   <= PWDATA[`BIT_INVERT];
			edge_reg     <= capture_edge_type'(PWDATA[`EDGE_LSB +: 2]);
			wave_reg     <= wave_mode_type'(PWDATA[`WAVE_LSB +: 2]);
		end
	end

	// Compare values
	// Next values already merge capture, software write and byte lanes
	always_ff @(posedge MCLK) begin
		if (RST) begin
			reg_a_reg <= `RST_WORD;
			reg_b_reg <= `RST_WORD;
		end else begin
			reg_a_reg <= reg_a_next;
			reg_b_reg <= reg_b_next;
		end
	end

	// Interrupt enables and flags
	// Reserved positions are masked in the next-value logic
	always_ff @(posedge MCLK) begin
		if (RST) begin
			irq_en_reg   <= `RST_IRQ;
			irq_flag_reg <= `RST_IRQ;
		end else begin
			irq_en_reg   <= irq_en_next;
			irq_flag_reg <= irq_flag_next;
		end
	end

	// Read data and error latched in the setup cycle
	// A write transfer latches zero so no stale word is presented
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rdata_reg  <= 32'h00000000;
			slverr_reg <= 1'b0;
		end else if (setup_ph) begin
			rdata_reg  <= PWRITE ? 32'h00000000 : rdata_next;
			slverr_reg <= ~hit_any;
		end
	end

endmodule : timer_capture_compare_ch

// [tb/timer_cc_monitor.sv]
// Port-level assertions for the timer channel
`timescale 1ns/1ns
`include "timer_cc_consts.svh"
module timer_cc_monitor (
	// Clock and reset
	input wire logic        MCLK,
	input wire logic        RST,
	// Register bus
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [19:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0]  PSTRB,
	input wire logic [31:0] PRDATA,
	// Pins
	input wire logic        CAPTURE_IN,
	input wire logic        TIMER_OUT,
	input wire logic        IRQ
);
	//********
	// Register mirrors
	//********
	wire        wr_acc = PSEL && PENABLE && PWRITE && PSTRB[0];
	wire [17:0] idx    = PADDR[19:2];
	logic [4:0] ien_m;
	logic       cap_m;
	logic [1:0] edge_m;

	// Track the enables and capture setup that software wrote
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ien_m  <= 5'h00;
			cap_m  <= 1'b0;
			edge_m <= 2'h0;
		end else if (wr_acc && idx == `IDX_IRQ_EN) begin
			ien_m <= PWDATA[4:0] & `IRQ_IMPL_MASK;
		end else if (wr_acc && idx == `IDX_CC_CTRL) begin
			cap_m  <= PWDATA[0];
			edge_m <= PWDATA[7:6];
		end
	end

	//********
	// Properties
	//********
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);

	sequence rd_acc(logic [17:0] i);
		PSEL && PENABLE && !PWRITE && idx == i;
	endsequence
	sequence off_wr;
		wr_acc && idx == `IDX_CC_CTRL && PWDATA[5:4] == `WAVE_OFF;
	endsequence

	reset_quiet_a: assert property (
		$fell(RST) |-> PRDATA == 32'h0 && !IRQ && !TIMER_OUT)
		else $error("Outputs not idle after reset");
	reset_bit_a: assert property (
		rd_acc(`IDX_COUNT_CTRL) |-> !PRDATA[1]) else $error("Reset bit reads one");
	ctrl_resv_a: assert property (
		rd_acc(`IDX_CC_CTRL) |-> PRDATA[15:8] == 8'h0 && PRDATA[3:2] == 2'h0)
		else $error("Control reserved bits read one");
	irq_resv_a: assert property (
		(rd_acc(`IDX_IRQ_EN) or rd_acc(`IDX_IRQ_FLAG)) |-> PRDATA[15:5] == 11'h0 && !PRDATA[3])
		else $error("Interrupt reserved bits read one");
	irq_gate_a: assert property (
		IRQ |-> ien_m != 5'h0) else $error("Interrupt with all causes masked");
	timer_off_a: assert property (
		off_wr |-> ##2 TIMER_OUT == $past(PWDATA[1], 2))
		else $error("Output off level wrong");
	cap_rise_a: assert property (
		cap_m && edge_m[0] && ien_m[2] && $rose(CAPTURE_IN) |-> ##[1:3] IRQ)
		else $error("Rising capture missed");
	cap_fall_a: assert property (
		cap_m && edge_m[1] && ien_m[2] && $fell(CAPTURE_IN) |-> ##[1:3] IRQ)
		else $error("Falling capture missed");
endmodule : timer_cc_monitor

bind timer_capture_compare_ch timer_cc_monitor u_timer_cc_monitor (.MCLK(MCLK), .RST(RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PSTRB(PSTRB), .PRDATA(PRDATA), .CAPTURE_IN(CAPTURE_IN), .TIMER_OUT(TIMER_OUT),
	.IRQ(IRQ));

// [tb/cc_far_side.sv]
// Capture source and timer output watcher beyond the channel pins
`timescale 1ns/1ns
module cc_far_side (
	// Clock
	input  wire logic       clk,
	// Pins
	input  wire logic       pin_in,
	output logic            cap_out,
	// Observation
	output logic [7:0]      toggles
);
	logic last;

	// Source idles low so reset sees no edge
	initial begin
		cap_out = 1'b0;
		last    = 1'b0;
		toggles = 8'h00;
	end

	// Count every change of the timer output level
	always @(posedge clk) begin
		last <= pin_in;
		if (pin_in !== last)
			toggles <= toggles + 8'h01;
	end

	// One high pulse, synchronous to the channel clock
	task automatic pulse(input int hi, input int lo);
		@(posedge clk);
		cap_out <= 1'b1;
		repeat (hi) @(posedge clk);
		cap_out <= 1'b0;
		repeat (lo) @(posedge clk);
	endtask : pulse
endmodule : cc_far_side

// [tb/tb_top.sv]
// Self-checking bench for the timer channel
`timescale 1ns/1ns
`include "timer_cc_consts.svh"
module tb_top;
	localparam logic [19:0] A_CNT = {`IDX_COUNT_CTRL, 2'h0};
	localparam logic [19:0] A_TC  = {`IDX_COUNTER, 2'h0};
	localparam logic [19:0] A_CC  = {`IDX_CC_CTRL, 2'h0};
	localparam logic [19:0] A_A   = {`IDX_REG_A, 2'h0};
	localparam logic [19:0] A_B   = {`IDX_REG_B, 2'h0};
	localparam logic [19:0] A_IE  = {`IDX_IRQ_EN, 2'h0};
	localparam logic [19:0] A_IF  = {`IDX_IRQ_FLAG, 2'h0};
	logic        MCLK    = 1'b0;
	logic        RST     = 1'b1;
	logic        PSEL    = 1'b0;
	logic        PENABLE = 1'b0;
	logic        PWRITE  = 1'b0;
	logic [19:0] PADDR   = 20'h0;
	logic [31:0] PWDATA  = 32'h0;
	wire  [31:0] PRDATA;
	wire         PREADY;
	wire         PSLVERR;
	wire         CAPTURE_IN;
	wire         TIMER_OUT;
	wire         IRQ;
	wire  [7:0]  tgl;
	logic [31:0] q;
	logic        e;
	int          n_fail      = 0;
	int          check_count = 0;

	// Bench clock
	always #50 MCLK = ~MCLK;

	timer_capture_compare_ch u_timer_capture_compare_ch (.MCLK(MCLK), .RST(RST),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PSTRB(4'hF), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.CAPTURE_IN(CAPTURE_IN), .TIMER_OUT(TIMER_OUT), .IRQ(IRQ));
	cc_far_side u_cc_far_side (.clk(MCLK), .pin_in(TIMER_OUT), .cap_out(CAPTURE_IN),
		.toggles(tgl));

	//********
	// Bus and check tasks
	//********
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One transfer, held until ready is seen high
	task automatic apb(input logic w, input logic [19:0] a, input logic [15:0] d);
		@(posedge MCLK);
		PSEL    <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE  <= w;
		PADDR   <= a;
		PWDATA  <= {16'h0000, d};
		@(posedge MCLK);
		PENABLE <= 1'b1;
		// Ready, read data and error are all taken at one rising edge
		do begin
			@(posedge MCLK);
		end while (PREADY !== 1'b1);
		q = PRDATA;
		e = PSLVERR;
		PSEL    <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [19:0] a, input logic [31:0] x);
		apb(1'b0, a, 16'h0000);
		check(q, x);
	endtask : rd

	// Interrupt level once the edge's updates have landed
	task automatic irq_is(input logic x);
		@(negedge MCLK);
		check({31'h0, IRQ}, {31'h0, x});
	endtask : irq_is

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	//********
	// Scenarios
	//********
	task automatic t_resets();
		logic [19:0] adr [7];
		adr = '{A_CNT, A_TC, A_CC, A_A, A_B, A_IE, A_IF};
		foreach (adr[i])
			rd(adr[i], 32'h0);
		irq_is(1'b0);
	endtask : t_resets

	task automatic t_regs();
		wr(A_A, 16'hA5C3);
		rd(A_A, 32'h0000A5C3);
		wr(A_B, 16'h5A3C);
		rd(A_B, 32'h00005A3C);
		wr(A_CC, 16'h00F3);
		rd(A_CC, 32'h000000F3);
		wr(A_IE, 16'h0017);
		rd(A_IE, 32'h00000017);
		wr(A_TC, 16'h1234);
		rd(A_TC, 32'h0);
		rd(20'h15138, 32'h0);
		check({31'h0, e}, 32'h1);
		wr(A_CC, 16'h0000);
	endtask : t_regs

	// One-shot periods through every output mode and polarity
	task automatic t_wave();
		logic [7:0] t0;
		int         xp [4];
		xp = '{0, 2, 1, 1};
		wr(A_A, 16'h0003);
		wr(A_B, 16'h0009);
		wr(A_IE, 16'h0003);
		for (int m = 0; m < 4; m++) begin
			for (int v = 0; v < 2; v++) begin
				wr(A_CC, 16'(m * 16 + v * 2));
				wr(A_CNT, 16'h0007);
				repeat (2) @(posedge MCLK);
				t0 = tgl;
				repeat (16) @(posedge MCLK);
				check({24'h0, tgl - t0}, 32'(xp[m]));
				check({31'h0, TIMER_OUT}, 32'(m[1] ^ v[0]));
			end
		end
		rd(A_CNT, 32'h4);
		rd(A_TC, 32'h0);
		rd(A_IF, 32'h3);
		irq_is(1'b1);
		wr(A_IF, 16'h0001);
		rd(A_IF, 32'h2);
		irq_is(1'b1);
		wr(A_IE, 16'h0001);
		irq_is(1'b0);
		wr(A_IF, 16'h0002);
		rd(A_IF, 32'h0);
	endtask : t_wave

	// Repeat counting, stop, then captures under every edge code
	task automatic t_capture();
		logic [15:0] c;
		logic [31:0] xf [4];
		xf = '{32'h0, 32'h4, 32'h4, 32'h14};
		wr(A_IE, 16'h0017);
		wr(A_B, 16'h0004);
		wr(A_CNT, 16'h0003);
		repeat (30) @(posedge MCLK);
		rd(A_CNT, 32'h1);
		apb(1'b0, A_TC, 16'h0000);
		check({31'h0, q[15:0] <= 16'h0004}, 32'h1);
		wr(A_B, 16'hFFFF);
		repeat (20) @(posedge MCLK);
		wr(A_CNT, 16'h0000);
		apb(1'b0, A_TC, 16'h0000);
		c = q[15:0];
		check({31'h0, c != 16'h0000}, 32'h1);
		rd(A_TC, {16'h0000, c});
		for (int k = 0; k < 4; k++) begin
			wr(A_CC, 16'(k * 64 + 1));
			wr(A_IF, 16'h0017);
			u_cc_far_side.pulse(3, 3);
			rd(A_IF, xf[k]);
		end
		rd(A_A, {16'h0000, c});
		wr(A_IF, 16'h0017);
		irq_is(1'b0);
	endtask : t_capture

	//********
	// Main sequence and watchdog
	//********
	initial begin
		repeat (12) @(posedge MCLK);
		RST <= 1'b0;
		t_resets();
		t_regs();
		t_wave();
		t_capture();
		tally_and_finish();
	end

	// Cut a hang short well past the expected run length
	initial begin
		#3000000;
		n_fail++;
		tally_and_finish();
	end
endmodule : tb_top
